// >>> design/fpae_core.sv
// Command framing, address extension and write protection gate
//
// Function
// - Complement set: bottom select 0 guards low blocks, 1 guards high blocks.
// - Erase or program touching a protected block is dropped.
// - Block locks count only when scheme select is one.
// - All block locks are set after power-up.
// - Upper address byte used only in three-byte mode.
// - Address bit 24 picks lower or upper half in three-byte mode.
// - Four-byte mode needs four address bytes, ignores upper byte register.
// - Any four-byte address reloads the upper address byte register unless the frame is refused as busy or misaligned.
// - Upper address byte clears at power-up and reset.
// - Single-line command starts at select fall, opcode MSB first.
// - Quad mode moves every byte as two nibbles, high first.
// - Select rising ends the command.
// - Reads may end after any bit.
// - Modifying commands need a whole byte count at select rise.
// - While busy, only status reads are accepted.
// - Address width flag reads 0 for three-byte, 1 for four.
// - Power-up address width chooses the starting mode.
// - Scheme zero uses level bits; scheme one uses block locks.
`timescale 1ns/1ps
`include "fpae_params.svh"
module fpae_core
(
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic         serial_clk,
    input  wire logic         chip_select_n,
    input  wire logic         serial_in,
    input  wire logic [3:0]   quad_lines,
    input  wire logic         quad_command_mode,
    input  wire logic         powerup_addr_width,
    input  wire logic         write_busy,
    input  wire logic         protect_scheme_select,
    input  wire logic         protect_complement,
    input  wire logic         protect_bottom_select,
    input  wire logic         protect_level_bit3,
    input  wire logic         protect_level_bit2,
    input  wire logic         protect_level_bit1,
    input  wire logic         protect_level_bit0,
    input  wire logic [511:0] block_lock_clear,
    output logic              current_addr_width_flag,
    output logic [7:0]        ext_addr_byte,
    output logic [31:0]       op_addr,
    output logic              erase_start,
    output logic              program_start,
    output logic              chip_erase,
    output logic              cmd_rejected,
    output logic [511:0]      block_lock
);
    fpae_pkg::fpae_state_type st_ff;
    fpae_pkg::fpae_state_type nxt_st;
    logic [511:0]             lock_ff;
    logic                     sclk_rise;
    logic                     cs_fall;
    logic                     cs_rise;
    logic                     cs_low;
    logic [3:0]               din;
    logic [7:0]               nxt_byte;
    logic                     byte_done;
    logic                     bit_cnt_zero;
    logic                     modify_op;
    logic                     four_op;
    logic                     status_op;
    logic                     prot_hit;
    logic [3:0]               level;
    logic [5:0]               addr_bits;
    logic                     strap_seen_ff;
    logic [31:0]              form_addr;

    assign level = {protect_level_bit3, protect_level_bit2,
                    protect_level_bit1, protect_level_bit0};

    // Edges of synchronised link signals
    assign sclk_rise = st_ff.sclk_sync[2:1] == 2'b01;
    assign cs_low    = !st_ff.csn_sync[1];
    assign din       = st_ff.din_sync1;

    // Edge detect kept off the first sync stage
    logic csn_d_ff;
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            csn_d_ff <= 1'b1;
        else
            csn_d_ff <= st_ff.csn_sync[1];
    end
    assign cs_fall = csn_d_ff && !st_ff.csn_sync[1];
    assign cs_rise = !csn_d_ff && st_ff.csn_sync[1];

    // nibble shift in quad mode, else bit shift
    assign nxt_byte  = quad_command_mode ? {st_ff.shift[3:0], din} :
                                           {st_ff.shift[6:0], din[0]};
    assign byte_done = quad_command_mode ? st_ff.bit_cnt[0] :
                                           (st_ff.bit_cnt[2:0] == 3'h7);
    assign bit_cnt_zero = quad_command_mode ? !st_ff.bit_cnt[0] :
                                              (st_ff.bit_cnt[2:0] == 3'h0);

    // Opcode classes
    always_comb
    begin
        case (st_ff.opcode)
            `FPAE_OP_PP4, `FPAE_OP_SE4, `FPAE_OP_BE4,
            `FPAE_OP_RD4: four_op = 1'b1;
            default:      four_op = 1'b0;
        endcase
        case (st_ff.opcode)
            `FPAE_OP_PP4, `FPAE_OP_SE4, `FPAE_OP_BE4, `FPAE_OP_PP,
            `FPAE_OP_SE, `FPAE_OP_BE, `FPAE_OP_CE, `FPAE_OP_CE2,
            `FPAE_OP_ENTER4B, `FPAE_OP_EXIT4B, `FPAE_OP_WREAR,
            `FPAE_OP_WREN: modify_op = 1'b1;
            default:       modify_op = 1'b0;
        endcase
        status_op = (st_ff.opcode == `FPAE_OP_RDSR1) ||
                    (st_ff.opcode == `FPAE_OP_RDSR2) ||
                    (st_ff.opcode == `FPAE_OP_RDSR3);
    end

    // four address bytes in four-byte mode or four-byte opcodes
    assign addr_bits = (st_ff.four_byte || four_op) ? 6'd32 : 6'd24;

    // upper byte joins the address only in three-byte mode
    assign form_addr = (st_ff.four_byte || four_op) ? st_ff.addr :
                       {st_ff.ext_addr, st_ff.addr[23:0]};

    fpae_range_check u_range
    (
        .blk        (form_addr[`FPAE_BLK_LSB +: `FPAE_BLK_W]),
        .whole      (st_ff.opcode == `FPAE_OP_CE || st_ff.opcode == `FPAE_OP_CE2),
        .scheme_sel (protect_scheme_select),
        .complement (protect_complement),
        .bottom_sel (protect_bottom_select),
        .level      (level),
        .block_lock (lock_ff),
        .hit        (prot_hit)
    );

    // Next state of the framing and address logic
    always_comb
    begin
        nxt_st             = st_ff;
        nxt_st.sclk_sync   = {st_ff.sclk_sync[1:0], serial_clk};
        nxt_st.csn_sync    = {st_ff.csn_sync[0], chip_select_n};
        nxt_st.din_sync0   = quad_command_mode ? quad_lines : {3'h0, serial_in};
        nxt_st.din_sync1   = st_ff.din_sync0;
        nxt_st.erase_pulse = 1'b0;
        nxt_st.prog_pulse  = 1'b0;
        nxt_st.wear_pulse  = 1'b0;
        nxt_st.reject      = 1'b0;
        if (cs_fall)
        begin
            nxt_st.phase   = fpae_pkg::FPAE_OPC;
            nxt_st.bit_cnt = 6'h0;
            nxt_st.addr    = 32'h0;
        end
        else if (cs_low && sclk_rise)
        begin
            nxt_st.shift   = nxt_byte;
            nxt_st.bit_cnt = st_ff.bit_cnt + 6'h1;
            case (st_ff.phase)
                fpae_pkg::FPAE_OPC:
                begin
                    if (byte_done)
                    begin
                        nxt_st.opcode  = nxt_byte;
                        nxt_st.bit_cnt = 6'h0;
                        nxt_st.phase   = fpae_pkg::FPAE_ADR;
                        // busy lets only status reads through
                        nxt_st.busy_cmd = write_busy;
                    end
                end
                fpae_pkg::FPAE_ADR:
                begin
                    nxt_st.addr = quad_command_mode ? {st_ff.addr[27:0], din} :
                                                      {st_ff.addr[30:0], din[0]};
                    if ((quad_command_mode ? {st_ff.bit_cnt[4:0], 2'b00} :
                         {1'b0, st_ff.bit_cnt}) == {1'b0, addr_bits - 6'h1} ||
                        (quad_command_mode && {st_ff.bit_cnt, 2'b00} ==
                         {2'b00, addr_bits} - 8'h4))
                    begin
                        nxt_st.bit_cnt = 6'h0;
                        nxt_st.phase   = fpae_pkg::FPAE_DAT;
                    end
                end
                fpae_pkg::FPAE_DAT:
                    nxt_st.bit_cnt = {3'h0, st_ff.bit_cnt[2:0] + 3'h1};
                default:
                    nxt_st.phase = fpae_pkg::FPAE_SKIP;
            endcase
        end
        else if (cs_rise && st_ff.phase != fpae_pkg::FPAE_OPC)
        begin
            nxt_st.phase = fpae_pkg::FPAE_OPC;
            // reads need no alignment; a non-status frame captured while busy is refused here
            if (st_ff.busy_cmd && !status_op)
                nxt_st.reject = 1'b1;
            // modifying command off byte boundary dropped
            else if (modify_op && !bit_cnt_zero)
                nxt_st.reject = 1'b1;
            else
            begin
                if ((st_ff.four_byte || four_op) && st_ff.phase == fpae_pkg::FPAE_DAT)
                    nxt_st.ext_addr = st_ff.addr[31:24];
                // upper byte only in three-byte mode
                nxt_st.target_addr = form_addr;
                case (st_ff.opcode)
                    `FPAE_OP_ENTER4B: nxt_st.four_byte = 1'b1;
                    `FPAE_OP_EXIT4B:  nxt_st.four_byte = 1'b0;
                    `FPAE_OP_WREAR:   nxt_st.ext_addr  = st_ff.addr[31:24];
                    default:          nxt_st.ext_addr  = nxt_st.ext_addr;
                endcase
                nxt_st.chip_all    = (st_ff.opcode == `FPAE_OP_CE) ||
                                     (st_ff.opcode == `FPAE_OP_CE2);
                // drop erase or program hitting protection
                if (modify_op && prot_hit &&
                    st_ff.opcode != `FPAE_OP_ENTER4B && st_ff.opcode != `FPAE_OP_EXIT4B &&
                    st_ff.opcode != `FPAE_OP_WREAR && st_ff.opcode != `FPAE_OP_WREN)
                    nxt_st.reject = 1'b1;
                else if (st_ff.opcode == `FPAE_OP_PP4 || st_ff.opcode == `FPAE_OP_PP)
                    nxt_st.prog_pulse = 1'b1;
                else if (modify_op && st_ff.opcode != `FPAE_OP_ENTER4B &&
                         st_ff.opcode != `FPAE_OP_EXIT4B &&
                         st_ff.opcode != `FPAE_OP_WREAR && st_ff.opcode != `FPAE_OP_WREN)
                    nxt_st.erase_pulse = 1'b1;
            end
        end
        // address width taken from the strap after reset release
        if (!strap_seen_ff)
            nxt_st.four_byte = powerup_addr_width;
    end

    // State register; reset clears upper byte and mode
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_ff         <= '0;
            st_ff.csn_sync <= 2'b11;
            strap_seen_ff <= 1'b0;
        end
        else
        begin
            // upper byte cleared by reset above
            st_ff         <= nxt_st;
            strap_seen_ff <= 1'b1;
        end
    end

    // Block locks, one flop each
    genvar gi;
    generate
        for (gi = 0; gi < `FPAE_NUM_BLK; gi = gi + 1)
        begin : g_lock
            always_ff @(posedge clk or negedge rst_b)
            begin
                if (!rst_b)
                    lock_ff[gi] <= 1'b1;
                else if (block_lock_clear[gi])
                    lock_ff[gi] <= 1'b0;
            end
        end
    endgenerate

    assign current_addr_width_flag = st_ff.four_byte;
    assign ext_addr_byte           = st_ff.ext_addr;
    assign op_addr                 = st_ff.target_addr;
    assign erase_start             = st_ff.erase_pulse;
    assign program_start           = st_ff.prog_pulse;
    assign chip_erase              = st_ff.chip_all;
    assign cmd_rejected            = st_ff.reject;
    assign block_lock              = lock_ff;
endmodule

// >>> inc/fpae_params.svh
// Constants for the flash protection and address extension block
`ifndef FPAE_PARAMS_SVH
`define FPAE_PARAMS_SVH
`define FPAE_BLK_W        9
`define FPAE_NUM_BLK      512
`define FPAE_LAST_BLK     9'h1ff
`define FPAE_LVL_MAX      4'h9
`define FPAE_BLK_LSB      16
`define FPAE_OP_ENTER4B   8'hb7
`define FPAE_OP_EXIT4B    8'he9
`define FPAE_OP_WREAR     8'hc5
`define FPAE_OP_RDSR1     8'h05
`define FPAE_OP_RDSR2     8'h35
`define FPAE_OP_RDSR3     8'h15
`define FPAE_OP_PP4       8'h12
`define FPAE_OP_SE4       8'h21
`define FPAE_OP_BE4       8'hdc
`define FPAE_OP_PP        8'h02
`define FPAE_OP_SE        8'h20
`define FPAE_OP_BE        8'hd8
`define FPAE_OP_CE        8'hc7
`define FPAE_OP_CE2       8'h60
`define FPAE_OP_RD4       8'h13
`define FPAE_OP_WREN      8'h06
`endif

// >>> inc/fpae_pkg.sv
// Types for the flash protection and address extension block
package fpae_pkg;
    typedef enum logic [1:0]
    {
        FPAE_OPC  = 2'b00,
        FPAE_ADR  = 2'b01,
        FPAE_DAT  = 2'b11,
        FPAE_SKIP = 2'b10
    } fpae_phase_type;

    typedef struct packed
    {
        logic [2:0]     sclk_sync;
        logic [1:0]     csn_sync;
        logic [3:0]     din_sync0;
        logic [3:0]     din_sync1;
        fpae_phase_type phase;
        logic [5:0]     bit_cnt;
        logic [7:0]     opcode;
        logic [31:0]    addr;
        logic [7:0]     shift;
        logic           four_byte;
        logic [7:0]     ext_addr;
        logic           busy_cmd;
        logic           erase_pulse;
        logic           prog_pulse;
        logic           wear_pulse;
        logic [31:0]    target_addr;
        logic           chip_all;
        logic           reject;
    } fpae_state_type;
endpackage

// >>> design/fpae_range_check.sv
// Protection range check for one target block or whole array
`timescale 1ns/1ps
`include "fpae_params.svh"
module fpae_range_check
(
    input  wire logic [8:0]   blk,
    input  wire logic         whole,
    input  wire logic         scheme_sel,
    input  wire logic         complement,
    input  wire logic         bottom_sel,
    input  wire logic [3:0]   level,
    input  wire logic [511:0] block_lock,
    output logic              hit
);
    logic [9:0] span;
    logic [9:0] lo;
    logic [9:0] hi;
    logic       none_p;
    logic       all_p;
    logic       in_rng;
    logic       any_lock;

    // Size, bounds and whole-array or empty cases of the level code
    always_comb
    begin
        span   = (level >= 4'h1 && level <= `FPAE_LVL_MAX) ?
                 10'(10'h1 << (level - 4'h1)) : 10'h0;
        none_p = 1'b0;
        all_p  = 1'b0;
        lo     = 10'h0;
        hi     = 10'h0;
        if (!complement)
        begin
            none_p = (level == 4'h0);
            all_p  = (level > `FPAE_LVL_MAX);
            lo     = bottom_sel ? 10'h0 : 10'(`FPAE_NUM_BLK) - span;
            hi     = bottom_sel ? span - 10'h1 : 10'(`FPAE_LAST_BLK);
        end
        else
        begin
            all_p  = (level == 4'h0);
            none_p = (level > `FPAE_LVL_MAX);
            lo     = bottom_sel ? span : 10'h0;
            hi     = bottom_sel ? 10'(`FPAE_LAST_BLK) : 10'(`FPAE_NUM_BLK) - span - 10'h1;
        end
        in_rng   = ({1'b0, blk} >= lo) && ({1'b0, blk} <= hi);
        any_lock = |block_lock;
        if (scheme_sel)
            hit = whole ? any_lock : block_lock[blk];
        else if (none_p)
            hit = 1'b0;
        else if (all_p || whole)
            hit = 1'b1;
        else
            hit = in_rng;
    end
endmodule

// >>> verif/fpae_host.sv
// Host serial flash controller model driving the link pins
`timescale 1ns/1ps
module fpae_host
(
    output logic       sclk,
    output logic       csn,
    output logic       sdi,
    output logic [3:0] qio,
    input  wire logic  quad
);
    // ****
    // Frame generation
    // ****
    initial
    begin
        {sclk, sdi, qio} = '0;
        csn = 1'b1;
    end

    task automatic put(input logic [7:0] b, input int n);
        for (int i = 0; i < (quad ? 2 : n); i++)
        begin
            if (quad)
                qio = i ? b[3:0] : b[7:4];
            else
                sdi = b[7 - i];
            #62.5 sclk = 1'b1;
            #62.5 sclk = 1'b0;
        end
    endtask

    task automatic frame(input logic [7:0] op, input int na, input logic [31:0] a,
                         input int nd, input int xb);
        csn = 1'b0;
        #62.5 put(op, 8);
        for (int i = na - 1; i >= 0; i--)
            put(a[8 * i +: 8], 8);
        for (int i = 0; i < nd; i++)
            put(8'h5a, 8);
        if (xb > 0)
            put(8'h96, xb);
        #62.5 csn = 1'b1;
        // Released lines show the inverse of their last value
        sdi = ~sdi;
        qio = ~qio;
        #250;
    endtask
endmodule

// >>> verif/fpae_chk.sv
// Port checks for the protection and address extension core
`timescale 1ns/1ps
module fpae_chk
(
    input wire logic         clk,
    input wire logic         rst_b,
    input wire logic         chip_select_n,
    input wire logic         powerup_addr_width,
    input wire logic         write_busy,
    input wire logic [511:0] block_lock_clear,
    input wire logic         current_addr_width_flag,
    input wire logic [7:0]   ext_addr_byte,
    input wire logic         erase_start,
    input wire logic         program_start,
    input wire logic         cmd_rejected,
    input wire logic [511:0] block_lock
);
    // ****
    // Assertions
    // ****
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    a_start_after_end: assert property (
        (erase_start || program_start) |-> chip_select_n && $past(chip_select_n, 2))
        else $error("start pulse inside a frame");
    a_busy_no_start: assert property (
        (erase_start || program_start) |-> !write_busy && !$past(write_busy, 4))
        else $error("start pulse while busy");
    a_reject_no_start: assert property (
        cmd_rejected |-> !erase_start && !program_start)
        else $error("reject and start together");
    a_flag_select_high: assert property (
        $changed(current_addr_width_flag) |-> chip_select_n)
        else $error("width flag moved inside a frame");
    a_ext_reset_clear: assert property (
        $rose(rst_b) |-> ext_addr_byte == 8'h00)
        else $error("upper byte not cleared by reset");
    a_locks_at_reset: assert property (
        $rose(rst_b) |-> &block_lock)
        else $error("locks not all set after reset");
    a_flag_from_strap: assert property (
        $rose(rst_b) |-> ##[1:2] current_addr_width_flag == powerup_addr_width)
        else $error("width flag does not follow strap");
    a_locks_never_set: assert property (
        (block_lock & ~$past(block_lock)) == '0)
        else $error("lock bit set outside reset");
    a_lock_clear_acts: assert property (
        (block_lock_clear != '0) |-> ##2 (block_lock & $past(block_lock_clear, 2)) == '0)
        else $error("lock bit not cleared");
endmodule

bind fpae_core fpae_chk chk
(
    .clk(clk), .rst_b(rst_b), .chip_select_n(chip_select_n),
    .powerup_addr_width(powerup_addr_width), .write_busy(write_busy),
    .block_lock_clear(block_lock_clear), .current_addr_width_flag(current_addr_width_flag),
    .ext_addr_byte(ext_addr_byte), .erase_start(erase_start), .program_start(program_start),
    .cmd_rejected(cmd_rejected), .block_lock(block_lock)
);

// >>> verif/tb.sv
// Self-checking bench for the protection and address extension core
`timescale 1ns/1ps
module tb;
    logic         clk, rst_b, sclk, csn, sdi, quad, strap, busy, scheme, comp, bot;
    logic         flag, er, pr, rej, ce;
    logic [3:0]   qio, lvl;
    logic [7:0]   ext;
    logic [31:0]  oaddr, a, r;
    logic [8:0]   blk;
    logic [511:0] lclr, locks;
    integer       seed;
    int           n_mismatch, comparisons, n_er, n_pr, n_rej, w;

    // ****
    // Clock, partner, core and pulse counters
    // ****
    always #5 clk = ~clk;
    fpae_host host (.sclk(sclk), .csn(csn), .sdi(sdi), .qio(qio), .quad(quad));
    fpae_core DUT
    (
        .clk(clk), .rst_b(rst_b), .serial_clk(sclk), .chip_select_n(csn), .serial_in(sdi),
        .quad_lines(qio), .quad_command_mode(quad), .powerup_addr_width(strap),
        .write_busy(busy), .protect_scheme_select(scheme), .protect_complement(comp),
        .protect_bottom_select(bot), .protect_level_bit3(lvl[3]), .protect_level_bit2(lvl[2]),
        .protect_level_bit1(lvl[1]), .protect_level_bit0(lvl[0]), .block_lock_clear(lclr),
        .current_addr_width_flag(flag), .ext_addr_byte(ext), .op_addr(oaddr),
        .erase_start(er), .program_start(pr), .chip_erase(ce), .cmd_rejected(rej),
        .block_lock(locks)
    );
    always @(posedge clk)
    begin
        n_er  <= n_er + int'(er);
        n_pr  <= n_pr + int'(pr);
        n_rej <= n_rej + int'(rej);
    end

    // Expected protection of one block under the level scheme
    function automatic logic prot(input logic c, input logic b, input logic [3:0] l,
                                  input logic [8:0] k);
        int fw;
        if (l == 4'h0)
            return c;
        if (l > 4'h9)
            return !c;
        fw = 1 << (l - 1);
        if (c)
            return b ? (k >= fw) : (k <= 511 - fw);
        return b ? (k < fw) : (k >= 512 - fw);
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // One frame; kind 0 nothing, 1 erase, 2 program, 3 refused
    task automatic cmd(input logic [7:0] op, input int na, input logic [31:0] ad,
                       input int nd, input int xb, input int kind);
        int e0, p0, r0;
        e0 = n_er;
        p0 = n_pr;
        r0 = n_rej;
        host.frame(op, na, ad, nd, xb);
        repeat (20) @(posedge clk);
        chk(n_er - e0, kind == 1, "erase pulses");
        chk(n_pr - p0, kind == 2, "program pulses");
        chk(n_rej - r0, kind == 3, "refusals");
    endtask

    task automatic summarize();
        if (n_mismatch == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Watchdog, about three times the expected run
    initial
    begin
        #1_000_000;
        n_mismatch++;
        summarize();
    end

    // ****
    // Main sequence
    // ****
    initial
    begin
        {clk, rst_b, quad, strap, busy, scheme, bot, lvl, lclr} = '0;
        comp = 1'b1;
        {n_mismatch, comparisons, n_er, n_pr, n_rej} = '0;
        seed = 82444;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        chk(32'(&locks), 32'h1, "locks");
        chk(32'(ext), 32'h0, "upper byte");
        chk(32'(flag), 32'h0, "width flag");
        cmd(8'hb7, 0, 32'h0, 0, 0, 0);
        chk(32'(flag), 32'h1, "width flag");
        cmd(8'hc5, 4, 32'h0700_0000, 0, 0, 0);
        chk(32'(ext), 32'h7, "upper byte");
        // Random level codes, blocks biased to range edges
        repeat (40)
        begin
            r = $random(seed);
            w = (r[31:28] inside {[1:9]}) ? 1 << (r[31:28] - 1) : 1;
            case (r[3:2])
                2'd0: blk = r[24:16];
                2'd1: blk = 9'(w - 1 + int'(r[4]));
                2'd2: blk = 9'(511 - w + int'(r[4]));
                default: blk = {9{r[5]}};
            endcase
            a = {7'h0, blk, r[15:0]};
            @(posedge clk);
            comp <= r[27];
            bot  <= r[26];
            lvl  <= r[31:28];
            @(posedge clk);
            if (prot(r[27], r[26], r[31:28], blk))
                cmd(8'hd8, 4, a, 0, 0, 3);
            else
            begin
                cmd(8'hd8, 4, a, 0, 0, 1);
                chk(oaddr, a, "address");
                chk(32'(ext), 32'(a[31:24]), "upper byte");
            end
        end
        @(posedge clk);
        comp <= 1'b1;
        lvl  <= 4'hc;
        cmd(8'hd8, 4, 32'h0123_0000, 0, 3, 3);
        cmd(8'h13, 4, 32'h0123_0000, 0, 5, 0);
        cmd(8'h12, 4, 32'h0104_0000, 1, 0, 2);
        chk(oaddr, 32'h0104_0000, "address");
        @(posedge clk);
        busy <= 1'b1;
        cmd(8'hd8, 4, 32'h0002_0000, 0, 0, 3);
        cmd(8'h05, 0, 32'h0, 0, 0, 0);
        @(posedge clk);
        busy <= 1'b0;
        quad <= 1'b1;
        cmd(8'hd8, 4, 32'h01a5_0000, 0, 0, 1);
        chk(oaddr, 32'h01a5_0000, "address");
        @(posedge clk);
        quad   <= 1'b0;
        scheme <= 1'b1;
        cmd(8'hd8, 4, 32'h0005_0000, 0, 0, 3);
        @(posedge clk);
        lclr <= 512'h20;
        @(posedge clk);
        lclr <= 512'h0;
        cmd(8'hd8, 4, 32'h0005_0000, 0, 0, 1);
        cmd(8'hd8, 4, 32'h0006_0000, 0, 0, 3);
        @(posedge clk);
        scheme <= 1'b0;
        cmd(8'hd8, 4, 32'h0006_0000, 0, 0, 1);
        cmd(8'he9, 0, 32'h0, 0, 0, 0);
        chk(32'(flag), 32'h0, "width flag");
        cmd(8'hd8, 3, 32'h0045_0000, 0, 0, 1);
        chk(oaddr, 32'h0045_0000, "address");
        cmd(8'hdc, 4, 32'h0130_0000, 0, 0, 1);
        chk(32'(ext), 32'h1, "upper byte");
        cmd(8'hd8, 3, 32'h0045_0000, 0, 0, 1);
        chk(oaddr, 32'h0145_0000, "address");
        chk(32'(ce), 32'h0, "chip erase");
        // Lower half guarded; upper byte must steer the check upward
        @(posedge clk);
        bot <= 1'b0;
        lvl <= 4'h9;
        cmd(8'hd8, 3, 32'h0045_0000, 0, 0, 1);
        cmd(8'hc7, 0, 32'h0, 0, 0, 3);
        @(posedge clk);
        lvl <= 4'hc;
        cmd(8'hc7, 0, 32'h0, 0, 0, 1);
        chk(32'(ce), 32'h1, "chip erase");
        @(posedge clk);
        lvl <= 4'h0;
        cmd(8'h60, 0, 32'h0, 0, 0, 3);
        // Second reset after the last frame, with the strap set
        strap <= 1'b1;
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        chk(32'(ext), 32'h0, "upper byte");
        chk(32'(flag), 32'h1, "width flag");
        summarize();
    end
endmodule
